// >>> tbf_pkg.sv
// Purpose: Shared constants and types for the token bus command framer
// Assumes: 50 MHz system clock
// Notes:   Offsets are AXI4-Lite byte addresses
`default_nettype none
package tbf_pkg;
  // ****************************************
  // Clock and link timing
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int RESP_MIN_NS = 74000;
  localparam int RESP_MAX_NS = 78000;
  localparam int IDLE_MIN_NS = 82000;
  localparam int IDLE_MAX_NS = 86000;
  localparam int RECONF_MS = 840;
  localparam int BLINK_MS = 250;
  localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_NS;
  localparam int IDLE_MIN_CYC = (IDLE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_MAX_CYC = IDLE_MAX_NS / CLK_NS;
  localparam int RECONF_CYC = RECONF_MS * (1000000 / CLK_NS);
  localparam int BLINK_CYC = BLINK_MS * (1000000 / CLK_NS);
  // ****************************************
  // Packet bytes and positions
  // ****************************************
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CONT = 8'h43;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] POS_FLAG = 8'h00;
  localparam logic [7:0] POS_HDR_LAST = 8'h06;
  localparam logic [7:0] POS_TEXT = 8'h07;
  localparam logic [7:0] POS_PKT_LAST = 8'hFF;
  // ****************************************
  // Status codes
  // ****************************************
  localparam logic [7:0] MODE_EDIT = 8'h01;
  localparam logic [7:0] MODE_VIEW = 8'h02;
  localparam logic [7:0] MODE_LOCAL = 8'h03;
  localparam logic [7:0] MODE_PANIC = 8'h04;
  localparam logic [7:0] ERR_MIN = 8'h14;
  localparam logic [7:0] ERR_INHIBIT = 8'h14;
  // ****************************************
  // Registers
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESP_T = 8'h08;
  localparam logic [7:0] REG_IDLE_T = 8'h0C;
  localparam logic [7:0] REG_RECONF_T = 8'h10;
  localparam logic CTRL_VIEW_RST = 1'b0;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tbf_txw_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic alters;
    logic [7:0] data;
    logic [7:0] src;
  } tbf_cmd_t;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_CMD  = 6'b000010,
    S_WAIT = 6'b000100,
    S_TEXT = 6'b001000,
    S_HDR  = 6'b010000,
    S_SEND = 6'b100000
  } tbf_state_t;
endpackage
`default_nettype wire

// >>> tbf_framer.sv
// Purpose: Command intake and response packet framing for the network port
// Assumes: Packet buffer of the network controller is written by address
// Notes:   One command in flight; others wait on o_cmd_ready
// Functional notes
// - Space flag when no packet follows
// - C flag on every packet but last
// - Bytes 0-6 status, text 7 to 255
// - Codes below twenty only report mode
// - Edit mode without error reports one
// - Failed command reports code twenty or more
// - View mode set by software reports two
// - View mode never restricts network commands
// - Local panel reports three
// - Emergency shutdown reports four
// - Reject settings-changing commands when local or shutdown
// - Rejection lasts until cause clears
// - Space ends code inside status region
// - Commands accepted with no login
// - Arrival order, reply to sender node
// - Trailing zero byte equals no terminator
// - Node ID from eight switches, MSB first
// - All-zero ID keeps device off network
// - Standard long-range response, idle, reconfiguration timing
// - Net LED lit on activity, blinks reconfiguring
// - Board LED lit on interface access
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tbf_framer import tbf_pkg::*; #(
  parameter int IDLE_MIN = IDLE_MIN_CYC,
  parameter int IDLE_MAX = IDLE_MAX_CYC,
  parameter int RECONF = RECONF_CYC,
  parameter int BLINK = BLINK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_node_sw,
  output logic o_net_join,
  output logic [7:0] o_node_id,
  input wire logic i_panel_local,
  input wire logic i_panic,
  input wire tbf_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_exec_valid,
  output logic o_exec_end,
  output logic [7:0] o_exec_data,
  input wire logic i_exec_ready,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_last,
  input wire logic [7:0] i_rsp_data,
  input wire logic [7:0] i_rsp_err,
  output logic o_rsp_ready,
  output tbf_txw_t o_tx,
  output logic o_tx_send,
  output logic [7:0] o_tx_dest,
  input wire logic i_tx_done,
  input wire logic i_link_token,
  input wire logic i_link_tx,
  input wire logic i_link_reconfig,
  input wire logic i_host_access,
  output logic o_led_net,
  output logic o_led_board
);
  // ****************************************
  // Declarations
  // ****************************************
  tbf_state_t state_reg;
  logic node_ok_reg;
  logic view_reg;
  logic inhib_reg;
  logic end_pend_reg;
  logic more_reg;
  logic [7:0] src_reg;
  logic [7:0] pos_reg;
  logic [7:0] code_reg;
  logic [7:0] mode_code;
  logic [7:0] hdr_byte;
  logic [7:0] d_hund;
  logic [7:0] d_tens;
  logic [7:0] d_ones;
  logic [1:0] n_dig;
  logic slot_free;
  logic cmd_take;
  logic drop_byte;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // ****************************************
  // Node identity
  // ****************************************
  // Switches are caught once after reset; moving them later has no effect
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      node_ok_reg <= 1'b0;
      o_node_id <= 8'h00;
    end else if (i_ce && !node_ok_reg) begin
      node_ok_reg <= 1'b1;
      o_node_id <= i_node_sw;
    end
  end
  // A zero ID never joins, so commands are never taken
  assign o_net_join = node_ok_reg && (o_node_id != 8'h00);

  // ****************************************
  // Status code
  // ****************************************
  // Shutdown outranks local; view is informational only
  always_comb begin
    if (i_panic) mode_code = MODE_PANIC;
    else if (i_panel_local) mode_code = MODE_LOCAL;
    else if (view_reg) mode_code = MODE_VIEW;
    else mode_code = MODE_EDIT;
  end

  // Decimal digits of the latched code, no leading zeros
  assign d_hund = code_reg / 8'd100;
  assign d_tens = (code_reg / 8'd10) % 8'd10;
  assign d_ones = code_reg % 8'd10;
  assign n_dig = (code_reg >= 8'd100) ? 2'd3 :
                 (code_reg >= 8'd10) ? 2'd2 : 2'd1;

  // Header byte at pos_reg: flag, digits, space, then space padding
  always_comb begin
    hdr_byte = CH_SPACE;
    if (pos_reg == POS_FLAG) begin
      hdr_byte = more_reg ? CH_CONT : CH_SPACE;
    end else if (n_dig == 2'd3) begin
      case (pos_reg)
        8'h01: hdr_byte = CH_ZERO + d_hund;
        8'h02: hdr_byte = CH_ZERO + d_tens;
        8'h03: hdr_byte = CH_ZERO + d_ones;
        default: hdr_byte = CH_SPACE;
      endcase
    end else if (n_dig == 2'd2) begin
      case (pos_reg)
        8'h01: hdr_byte = CH_ZERO + d_tens;
        8'h02: hdr_byte = CH_ZERO + d_ones;
        default: hdr_byte = CH_SPACE;
      endcase
    end else if (pos_reg == 8'h01) begin
      hdr_byte = CH_ZERO + d_ones;
    end
  end

  // ****************************************
  // Command intake
  // ****************************************
  // The hand-off slot is one byte deep; it drains before a reply starts
  assign slot_free = !o_exec_valid || i_exec_ready;
  assign drop_byte = inhib_reg || (i_cmd.last && i_cmd.data == CH_NUL);
  // No login: any sender is taken as soon as the device is joined
  assign o_cmd_ready = (state_reg == S_CMD) && !end_pend_reg &&
                       (inhib_reg || slot_free);
  assign cmd_take = o_cmd_ready && i_cmd.valid;
  assign o_rsp_ready = (state_reg == S_TEXT);

  // Exec slot: data bytes, then an end marker per command that is not inhibited
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_exec_valid <= 1'b0;
      o_exec_end <= 1'b0;
      o_exec_data <= 8'h00;
    end else if (i_ce) begin
      if (cmd_take && !drop_byte) begin
        o_exec_valid <= 1'b1;
        o_exec_end <= 1'b0;
        o_exec_data <= i_cmd.data;
      end else if (state_reg == S_CMD && end_pend_reg && !inhib_reg &&
                   slot_free) begin
        o_exec_valid <= 1'b1;
        o_exec_end <= 1'b1;
        o_exec_data <= 8'h00;
      end else if (i_exec_ready) begin
        o_exec_valid <= 1'b0;
        o_exec_end <= 1'b0;
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // One command at a time keeps replies in arrival order
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      inhib_reg <= 1'b0;
      end_pend_reg <= 1'b0;
      more_reg <= 1'b0;
      src_reg <= 8'h00;
      pos_reg <= 8'h00;
      code_reg <= MODE_EDIT;
      o_tx <= '0;
      o_tx_send <= 1'b0;
    end else if (i_ce) begin
      o_tx.wr <= 1'b0;
      o_tx_send <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (o_net_join && i_cmd.valid) begin
            src_reg <= i_cmd.src;
            // Inhibition is judged at the first byte and holds for the whole command
            inhib_reg <= i_cmd.alters && (i_panel_local || i_panic);
            end_pend_reg <= 1'b0;
            state_reg <= S_CMD;
          end
        end
        S_CMD: begin
          if (cmd_take && i_cmd.last) begin
            end_pend_reg <= 1'b1;
          end else if (end_pend_reg && inhib_reg) begin
            code_reg <= ERR_INHIBIT;
            more_reg <= 1'b0;
            pos_reg <= POS_FLAG;
            state_reg <= S_HDR;
          end else if (end_pend_reg && slot_free) begin
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (i_rsp_valid) begin
            code_reg <= (i_rsp_err >= ERR_MIN) ? i_rsp_err : mode_code;
            pos_reg <= POS_TEXT;
            state_reg <= S_TEXT;
          end
        end
        S_TEXT: begin
          if (i_rsp_valid) begin
            o_tx.wr <= 1'b1;
            o_tx.addr <= pos_reg;
            o_tx.data <= i_rsp_data;
            if (i_rsp_last || pos_reg == POS_PKT_LAST) begin
              more_reg <= !i_rsp_last;
              pos_reg <= POS_FLAG;
              state_reg <= S_HDR;
            end else begin
              pos_reg <= pos_reg + 8'h01;
            end
          end
        end
        S_HDR: begin
          o_tx.wr <= 1'b1;
          o_tx.addr <= pos_reg;
          o_tx.data <= hdr_byte;
          if (pos_reg == POS_HDR_LAST) begin
            o_tx_send <= 1'b1;
            state_reg <= S_SEND;
          end else begin
            pos_reg <= pos_reg + 8'h01;
          end
        end
        S_SEND: begin
          if (i_tx_done) begin
            pos_reg <= POS_TEXT;
            state_reg <= more_reg ? S_TEXT : S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  assign o_tx_dest = src_reg;

  // ****************************************
  // Indicators
  // ****************************************
  // Blink pace is slow enough to see during a reconfiguration
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (i_ce) begin
      if (blink_cnt_reg >= 32'(BLINK - 1)) begin
        blink_cnt_reg <= 32'h0;
        blink_reg <= !blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
    end
  end
  assign o_led_net = i_link_reconfig ? blink_reg :
                     (i_link_token || i_link_tx);
  assign o_led_board = i_host_access || o_tx.wr || o_tx_send;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Address and data are taken in either order; reply once both are held
  assign o_s_axi_awready = !aw_have_reg && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_have_reg && !o_s_axi_bvalid;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= AXI_OKAY;
      view_reg <= CTRL_VIEW_RST;
    end else if (i_ce) begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (aw_have_reg && w_have_reg && !o_s_axi_bvalid) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == REG_CTRL) begin
          o_s_axi_bresp <= AXI_OKAY;
          if (w_strb_reg[0]) view_reg <= w_data_reg[0];
        end else if (aw_addr_reg == REG_STATUS ||
                     aw_addr_reg == REG_RESP_T ||
                     aw_addr_reg == REG_IDLE_T ||
                     aw_addr_reg == REG_RECONF_T) begin
          o_s_axi_bresp <= AXI_OKAY;
        end else begin
          o_s_axi_bresp <= AXI_SLVERR;
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  assign o_s_axi_arready = !o_s_axi_rvalid;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= AXI_OKAY;
    end else if (i_ce) begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= AXI_OKAY;
        case (i_s_axi_araddr)
          REG_CTRL: o_s_axi_rdata <= {31'h0, view_reg};
          REG_STATUS: o_s_axi_rdata <= {code_reg, o_node_id, 5'h00,
            (state_reg != S_IDLE), i_panic, i_panel_local,
            o_net_join, more_reg, state_reg};
          // Link timing handed to the network controller
          REG_RESP_T: o_s_axi_rdata <= {16'(RESP_MAX_CYC),
                                        16'(RESP_MIN_CYC)};
          REG_IDLE_T: o_s_axi_rdata <= {16'(IDLE_MAX), 16'(IDLE_MIN)};
          REG_RECONF_T: o_s_axi_rdata <= 32'(RECONF);
          default: begin
            o_s_axi_rdata <= 32'h0;
            o_s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  property p_last_flag;
    o_tx.wr && o_tx.addr == POS_FLAG && !more_reg |-> o_tx.data == CH_SPACE;
  endproperty
  a_last_flag: assert property (p_last_flag)
    else $error("last packet flag not space");

  property p_cont_flag;
    o_tx.wr && o_tx.addr == POS_FLAG && more_reg |-> o_tx.data == CH_CONT;
  endproperty
  a_cont_flag: assert property (p_cont_flag)
    else $error("continued packet flag not C");

  property p_hdr_run;
    i_ce && state_reg == S_HDR && pos_reg == POS_FLAG |-> i_ce [*7] ##1
      o_tx.addr == POS_HDR_LAST && o_tx_send;
  endproperty
  a_hdr_run: assert property (p_hdr_run)
    else $error("header not seven bytes before send");

  property p_hdr_space;
    o_tx.wr && o_tx.addr == POS_HDR_LAST |-> o_tx.data == CH_SPACE;
  endproperty
  a_hdr_space: assert property (p_hdr_space)
    else $error("status region not ended by space");

  property p_inhibit;
    state_reg == S_CMD && inhib_reg |-> !o_exec_valid;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibited command forwarded");

  property p_local_code;
    i_ce && state_reg == S_WAIT && i_rsp_valid && i_rsp_err < ERR_MIN &&
      i_panel_local && !i_panic |=> code_reg == MODE_LOCAL;
  endproperty
  a_local_code: assert property (p_local_code)
    else $error("local code not three");

  property p_panic_code;
    i_ce && state_reg == S_WAIT && i_rsp_valid && i_rsp_err < ERR_MIN &&
      i_panic |=> code_reg == MODE_PANIC;
  endproperty
  a_panic_code: assert property (p_panic_code)
    else $error("shutdown code not four");

  property p_err_code;
    i_ce && state_reg == S_WAIT && i_rsp_valid && i_rsp_err >= ERR_MIN
      |=> code_reg == $past(i_rsp_err);
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("error code not reported");

  property p_zero_id;
    node_ok_reg && o_node_id == 8'h00 |-> !o_net_join && !o_cmd_ready;
  endproperty
  a_zero_id: assert property (p_zero_id)
    else $error("zero node id joined");
endmodule // tbf_framer
`default_nettype wire

// >>> tbf_host_pm.sv
// Purpose: Instrument and packet buffer model on the far side of the framer
// Assumes: One command executed at a time
// Notes:   Takes exec slots every other cycle to stall the framer
`timescale 1ns/1ps
`default_nettype none
module tbf_host_pm import tbf_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_exec_valid,
  input wire logic i_exec_end,
  output logic o_exec_ready,
  input wire logic i_rsp_ready,
  output logic o_rsp_valid,
  output logic o_rsp_last,
  output logic [7:0] o_rsp_data,
  output logic [7:0] o_rsp_err,
  input wire logic i_tx_send,
  output logic o_tx_done,
  input wire logic [8:0] i_len,
  input wire logic [7:0] i_err,
  output logic [7:0] o_cnt
);
  logic busy_reg, slow_reg;
  logic [8:0] idx_reg;
  logic [7:0] run_reg;
  logic [2:0] done_reg;
  // Count command bytes, then stream i_len reply bytes
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      busy_reg <= 1'b0;
      slow_reg <= 1'b0;
      idx_reg <= 9'h000;
      run_reg <= 8'h00;
      o_cnt <= 8'h00;
      done_reg <= 3'h0;
    end else begin
      slow_reg <= ~slow_reg;
      done_reg <= {done_reg[1:0], i_tx_send};
      if (i_exec_valid && o_exec_ready) begin
        if (i_exec_end) begin
          busy_reg <= 1'b1;
          idx_reg <= 9'h000;
          o_cnt <= run_reg;
          run_reg <= 8'h00;
        end else begin
          run_reg <= run_reg + 8'h01;
        end
      end
      if (o_rsp_valid && i_rsp_ready) begin
        idx_reg <= idx_reg + 9'h001;
        if (o_rsp_last) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end
  // Idle data lines show the inverted index, not the last byte
  assign o_exec_ready = slow_reg;
  assign o_rsp_valid = busy_reg;
  assign o_rsp_last = (idx_reg == i_len - 9'h001);
  assign o_rsp_data = busy_reg ? idx_reg[7:0] : ~idx_reg[7:0];
  assign o_rsp_err = i_err;
  assign o_tx_done = done_reg[2];
endmodule // tbf_host_pm
`default_nettype wire

// >>> token_bus_command_response_framer_tb.sv
// Purpose: Self-checking bench for the response framer
// Assumes: Host model answers every executed command
// Notes:   Short timers keep the run brief
`timescale 1ns/1ps
`default_nettype none
module token_bus_command_response_framer_tb import tbf_pkg::*;;
  logic clk, rst, awv, wv, bready, arv, rready, plocal, panic, reconf;
  logic awready, wready, bvalid, arready, rvalid, join_o, cmd_ready;
  logic exv, exe, exr, rspv, rspl, rspr, tx_send, tx_done;
  logic token, ltx, host_acc, led_net, led_board;
  logic [7:0] awaddr, araddr, sw, node_id, exd, rspd, rspe, dest, perr, pcnt;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] strb;
  logic [8:0] plen;
  logic [7:0] pkt [0:255];
  logic [7:0] flg [0:15];
  tbf_cmd_t cmd_s;
  tbf_txw_t tx;
  int errors, compares, sends;
  // ****************************************
  // Clock, instances and packet capture
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  tbf_framer #(.IDLE_MIN(4), .IDLE_MAX(8), .RECONF(16), .BLINK(4)) dut (
    .i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(strb), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_node_sw(sw), .o_net_join(join_o),
    .o_node_id(node_id), .i_panel_local(plocal), .i_panic(panic),
    .i_cmd(cmd_s), .o_cmd_ready(cmd_ready), .o_exec_valid(exv),
    .o_exec_end(exe), .o_exec_data(exd), .i_exec_ready(exr),
    .i_rsp_valid(rspv), .i_rsp_last(rspl), .i_rsp_data(rspd),
    .i_rsp_err(rspe), .o_rsp_ready(rspr), .o_tx(tx), .o_tx_send(tx_send),
    .o_tx_dest(dest), .i_tx_done(tx_done), .i_link_token(token),
    .i_link_tx(ltx), .i_link_reconfig(reconf), .i_host_access(host_acc),
    .o_led_net(led_net), .o_led_board(led_board));
  tbf_host_pm pm (.i_sys_clk(clk), .i_reset(rst), .i_exec_valid(exv),
    .i_exec_end(exe), .o_exec_ready(exr), .i_rsp_ready(rspr),
    .o_rsp_valid(rspv), .o_rsp_last(rspl), .o_rsp_data(rspd),
    .o_rsp_err(rspe), .i_tx_send(tx_send), .o_tx_done(tx_done),
    .i_len(plen), .i_err(perr), .o_cnt(pcnt));
  // Packet buffer mirror; flag byte per sent packet
  always @(posedge clk) begin
    if (tx.wr) pkt[tx.addr] <= tx.data;
    if (tx_send) begin
      flg[sends[3:0]] <= pkt[0];
      sends <= sends + 1;
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int t, input int lim);
    if (t >= lim) begin
      errors++;
      $display("MISMATCH wait exp done seen timeout");
      end_of_test;
    end
  endtask
  // Address and data together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aa, ww;
    int t;
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    for (t = 0; t < 50 && (t == 0 || awv || wv); t++) begin
      @(negedge clk);
      aa = awv & awready;
      ww = wv & wready;
      @(posedge clk);
      if (aa) awv <= 1'b0;
      if (ww) wv <= 1'b0;
    end
    for (t = 0; t < 50 && bvalid !== 1'b1; t++) @(negedge clk);
    tmo(t, 50);
    chk("bresp", bresp, er);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int t;
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(negedge clk);
      if (arready === 1'b1) break;
    end
    @(posedge clk);
    arv <= 1'b0;
    for (t = 0; t < 50 && rvalid !== 1'b1; t++) @(negedge clk);
    tmo(t, 50);
    chk("rdata", rdata, d);
    chk("rresp", rresp, er);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // n bytes 'A'.., an optional zero byte, then wait for np packets
  task automatic cmd(input logic [7:0] src, input logic alt, input int n,
                     input logic nul, input int np);
    int k, t, tot, base;
    tot = n + nul;
    base = sends;
    for (k = 0; k < tot; k++) begin
      cmd_s <= '{1'b1, k == tot - 1, alt, (k < n) ? 8'h41 + k : CH_NUL, src};
      for (t = 0; t < 400 && (t == 0 || cmd_ready !== 1'b1); t++)
        @(negedge clk);
      tmo(t, 400);
      @(posedge clk);
    end
    cmd_s.valid <= 1'b0;
    for (t = 0; t < 3000 && sends < base + np; t++) @(negedge clk);
    tmo(t, 3000);
  endtask
  // Status region: flag, code, space, padding
  task automatic hdr(input logic [7:0] fl, input int code);
    logic [7:0] e [0:6];
    int i;
    for (i = 0; i < 7; i++) e[i] = CH_SPACE;
    e[0] = fl;
    if (code >= 10) begin
      e[1] = CH_ZERO + code / 10;
      e[2] = CH_ZERO + code % 10;
    end else begin
      e[1] = CH_ZERO + code;
    end
    for (i = 0; i < 7; i++) chk("status byte", pkt[i], e[i]);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_node;
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("join zero id", join_o, 1'b0);
    rst <= 1'b1;
    sw <= 8'hA5;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("node id", node_id, 8'hA5);
    chk("join", join_o, 1'b1);
  endtask
  task automatic s_edit;
    cmd(8'h07, 1'b1, 3, 1'b1, 1);
    hdr(CH_SPACE, 1);
    chk("text first", pkt[7], 8'h00);
    chk("text third", pkt[9], 8'h02);
    chk("dest", dest, 8'h07);
    chk("exec bytes", pcnt, 8'h03);
  endtask
  task automatic s_view;
    axi_wr(REG_CTRL, 32'h0000_0001, AXI_OKAY);
    strb <= 4'h0;
    axi_wr(REG_CTRL, 32'h0, AXI_OKAY);
    strb <= 4'hF;
    axi_rd(REG_CTRL, 32'h0000_0001, AXI_OKAY);
    cmd(8'h09, 1'b1, 2, 1'b0, 1);
    hdr(CH_SPACE, 2);
    chk("view exec", pcnt, 8'h02);
    chk("dest view", dest, 8'h09);
    axi_wr(REG_CTRL, 32'h0000_0000, AXI_OKAY);
    axi_rd(8'h40, 32'h0000_0000, AXI_SLVERR);
    axi_wr(8'h40, 32'h0000_0001, AXI_SLVERR);
  endtask
  task automatic s_err;
    perr <= 8'd25;
    cmd(8'h07, 1'b0, 1, 1'b0, 1);
    hdr(CH_SPACE, 25);
    perr <= 8'h00;
  endtask
  task automatic s_inhibit;
    plocal <= 1'b1;
    cmd(8'h07, 1'b0, 4, 1'b0, 1);
    hdr(CH_SPACE, 3);
    cmd(8'h07, 1'b1, 2, 1'b0, 1);
    hdr(CH_SPACE, 20);
    chk("no exec local", pcnt, 8'h04);
    plocal <= 1'b0;
    panic <= 1'b1;
    cmd(8'h09, 1'b0, 4, 1'b0, 1);
    hdr(CH_SPACE, 4);
    cmd(8'h09, 1'b1, 1, 1'b0, 1);
    hdr(CH_SPACE, 20);
    chk("no exec panic", pcnt, 8'h04);
    panic <= 1'b0;
    cmd(8'h09, 1'b1, 5, 1'b0, 1);
    hdr(CH_SPACE, 1);
    chk("exec after clear", pcnt, 8'h05);
  endtask
  task automatic s_multi;
    int base;
    base = sends;
    plen <= 9'd260;
    cmd(8'h07, 1'b0, 2, 1'b0, 2);
    chk("flag first", flg[base[3:0]], CH_CONT);
    chk("flag last", flg[base[3:0] + 4'h1], CH_SPACE);
    chk("second text", pkt[7], 8'hF9);
    chk("second tail", pkt[17], 8'h03);
    plen <= 9'd3;
  endtask
  task automatic s_led;
    logic b;
    host_acc <= 1'b1;
    token <= 1'b1;
    @(negedge clk);
    chk("board led", led_board, 1'b1);
    chk("net led", led_net, 1'b1);
    @(posedge clk);
    host_acc <= 1'b0;
    token <= 1'b0;
    reconf <= 1'b1;
    @(negedge clk);
    b = led_net;
    repeat (4) @(negedge clk);
    chk("blink", led_net, !b);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0; compares = 0; sends = 0;
    rst = 1'b1; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0; strb = 4'hF;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    sw = 8'h00; plocal = 1'b0; panic = 1'b0; token = 1'b0; ltx = 1'b0;
    host_acc = 1'b0; cmd_s = '0; plen = 9'd3; perr = 8'h00; reconf = 1'b0;
    repeat (8) @(posedge clk);
    s_node;
    s_edit;
    s_view;
    s_err;
    s_inhibit;
    s_multi;
    s_led;
    end_of_test;
  end
endmodule // token_bus_command_response_framer_tb
`default_nettype wire
